// ---- design/ecc_defs.vh ----
// Constants for the encoder counter control block: register map, fields, resets.
// Included by the design files by bare name; holds definitions only.
`ifndef ECC_DEFS_VH
`define ECC_DEFS_VH

// Byte offsets on the Avalon-MM slave (one aligned 32-bit word each)
`define ECC_OFS_CTRL 6'h00
`define ECC_OFS_INIT 6'h04
`define ECC_OFS_MAX 6'h08
`define ECC_OFS_WDPRD 6'h0c
`define ECC_OFS_UPRD 6'h10
`define ECC_OFS_POS 6'h14
`define ECC_OFS_WDCNT 6'h18
`define ECC_OFS_UTCNT 6'h1c
`define ECC_OFS_CTCNT 6'h20
`define ECC_OFS_STAT 6'h24

// Control register fields
`define ECC_EMU_HI 15
`define ECC_EMU_LO 14
`define ECC_POSITION_RESET_MODE_HI 13
`define ECC_POSITION_RESET_MODE_LO 12
`define ECC_SEI_HI 11
`define ECC_SEI_LO 10

// Emulation codes
`define ECC_EMU_STOP 2'h0
`define ECC_EMU_ROLL 2'h1

// Position reset modes
`define ECC_POSITION_RESET_MODE_INDEX 2'h0
`define ECC_POSITION_RESET_MODE_MAX 2'h1
`define ECC_POSITION_RESET_MODE_FIRST 2'h2
`define ECC_POSITION_RESET_MODE_UNIT 2'h3

// Strobe initialization codes
`define ECC_SEI_RISE 2'h2
`define ECC_SEI_DIR 2'h3

// Status bits
`define ECC_STAT_WTO 0
`define ECC_STAT_UTO 1
`define ECC_STAT_DIR 2

// Reset values
`define ECC_CTRL_RST 16'h0000
`define ECC_WORD_RST 32'h00000000
`define ECC_HALF_RST 16'h0000

// Watchdog prescale: one tick every 64 clocks
`define ECC_WD_PRESCALE 6'h3f

`endif

// ---- design/ecc_susp.v ----
// Suspend gate for one counter: decides whether the counter may advance.
// Expects a level suspend input and a one-cycle rollover pulse from the counter.
`timescale 1ns/1ps
`include "ecc_defs.vh"

module ecc_susp (
  input wire ref_clk, // System clock
  input wire rst_b, // Async reset, active low
  input wire emu_suspend, // Debugger halt, level
  input wire [1:0] emu_mode, // Emulation field
  input wire rollover, // Counter rollover pulse
  output wire run // Counter may advance
);

  reg stop_r;
  wire stop_nxt;

  // Latch stop at the first rollover seen under suspend; free again on release
  assign stop_nxt = !emu_suspend ? 1'b0 : (stop_r | (emu_mode == `ECC_EMU_ROLL && rollover));

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      stop_r <= 1'b0;
    end else begin
      stop_r <= stop_nxt;
    end
  end

  assign run = !emu_suspend | emu_mode[1] | (emu_mode == `ECC_EMU_ROLL && !stop_r);

endmodule // ecc_susp

// ---- design/ecc_top.v ----
// Encoder counter control: position, watchdog, unit and capture counters with
// emulation suspend, position reset modes and strobe initialization.
// Assumes decoded count pulse/direction and index/strobe synchronous to ref_clk.
//
// How it works
// R01: Position count obeys emulation field on suspend
// R02: Watchdog count obeys emulation field on suspend
// R03: Unit timer obeys emulation field on suspend
// R04: Capture timer obeys emulation field on suspend, stopping at unit event
// R05: Mode 00 resets position on index
// R06: Mode 01 resets position at maximum
// R07: Mode 10 resets only on first index
// R08: Mode 11 resets position on unit event
// R09: Strobe codes 00/01 do nothing
// R10: Code 10 loads on strobe rise
// R11: Code 11 loads on rise when clockwise
// R12: Code 11 loads on fall when counter-clockwise
// R13: Loads take the programmed init value
// R14: Debugger holds suspend high while halted
`timescale 1ns/1ps
`include "ecc_defs.vh"

module ecc_top (
  input wire ref_clk, // 40 MHz system clock
  input wire rst_b, // Async reset, active low
  input wire [5:0] avs_address, // Byte address
  input wire avs_read, // Read request
  input wire avs_write, // Write request
  input wire [31:0] avs_writedata, // Write data
  input wire [3:0] avs_byteenable, // Byte lanes
  output wire [31:0] avs_readdata, // Read data
  output wire avs_waitrequest, // Stall
  input wire count_pulse, // Decoded quadrature count pulse
  input wire count_dir, // Direction, high is clockwise
  input wire index_input, // Index line
  input wire strobe_input, // Strobe line
  input wire emu_suspend, // Debugger halt level
  output wire [31:0] position_count, // Position count
  output wire unit_event // Unit time event pulse
);

  function [31:0] merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0] be;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i]) begin
          merge[i*8 +: 8] = wd[i*8 +: 8];
        end
      end
    end
  endfunction

  reg ack_r;
  reg [31:0] rdata_r;
  reg [15:0] ctrl_r;
  reg [31:0] init_r;
  reg [31:0] max_r;
  reg [15:0] wdprd_r;
  reg [31:0] uprd_r;
  reg [31:0] pos_r;
  reg [31:0] pos_nxt;
  reg [15:0] wd_r;
  reg [5:0] pre_r;
  reg [31:0] ut_r;
  reg [15:0] ct_r;
  reg idx_d_r;
  reg strb_d_r;
  reg arm_r;
  reg wto_r;
  reg uto_r;
  reg [31:0] rdata_nxt;

  wire [1:0] emu_mode;
  wire [1:0] position_reset_mode;
  wire [1:0] strobe_init_select;
  wire run_p;
  wire run_w;
  wire run_u;
  wire run_c;
  wire wr_go;
  wire rd_go;
  wire idx_rise;
  wire strb_rise;
  wire strb_fall;
  wire step;
  wire at_max;
  wire at_zero;
  wire pos_roll;
  wire init_evt;
  wire rst_evt;
  wire wd_tick;
  wire wd_match;
  wire u_match;
  wire ctrl_wr;
  wire stat_wr;
  wire [31:0] ctrl_mrg;
  wire [31:0] wdprd_mrg;

  assign emu_mode = ctrl_r[`ECC_EMU_HI:`ECC_EMU_LO];
  assign position_reset_mode = ctrl_r[`ECC_POSITION_RESET_MODE_HI:`ECC_POSITION_RESET_MODE_LO];
  assign strobe_init_select = ctrl_r[`ECC_SEI_HI:`ECC_SEI_LO];

  // Bus: one wait cycle, then the access completes
  assign avs_waitrequest = (avs_read | avs_write) & !ack_r;
  assign wr_go = avs_write & ack_r;
  assign rd_go = avs_read & !ack_r;
  assign avs_readdata = rdata_r;
  assign ctrl_wr = wr_go && avs_address == `ECC_OFS_CTRL;
  assign stat_wr = wr_go && avs_address == `ECC_OFS_STAT;
  // 16-bit registers merge in a full word, then keep the low half
  assign ctrl_mrg = merge({16'h0000, ctrl_r}, avs_writedata, avs_byteenable);
  assign wdprd_mrg = merge({16'h0000, wdprd_r}, avs_writedata, avs_byteenable);

  always @* begin
    rdata_nxt = 32'h00000000;
    case (avs_address)
      `ECC_OFS_CTRL: rdata_nxt = {16'h0000, ctrl_r};
      `ECC_OFS_INIT: rdata_nxt = init_r;
      `ECC_OFS_MAX: rdata_nxt = max_r;
      `ECC_OFS_WDPRD: rdata_nxt = {16'h0000, wdprd_r};
      `ECC_OFS_UPRD: rdata_nxt = uprd_r;
      `ECC_OFS_POS: rdata_nxt = pos_r;
      `ECC_OFS_WDCNT: rdata_nxt = {16'h0000, wd_r};
      `ECC_OFS_UTCNT: rdata_nxt = ut_r;
      `ECC_OFS_CTCNT: rdata_nxt = {16'h0000, ct_r};
      `ECC_OFS_STAT: rdata_nxt = {29'h00000000, count_dir, uto_r, wto_r};
      default: rdata_nxt = 32'h00000000;
    endcase
  end

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_r <= 1'b0;
      rdata_r <= `ECC_WORD_RST;
    end else begin
      ack_r <= (avs_read | avs_write) & !ack_r;
      if (rd_go) begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= `ECC_CTRL_RST;
      init_r <= `ECC_WORD_RST;
      max_r <= `ECC_WORD_RST;
      wdprd_r <= `ECC_HALF_RST;
      uprd_r <= `ECC_WORD_RST;
    end else if (wr_go) begin
      case (avs_address)
        `ECC_OFS_CTRL: ctrl_r <= ctrl_mrg[15:0];
        `ECC_OFS_INIT: init_r <= merge(init_r, avs_writedata, avs_byteenable);
        `ECC_OFS_MAX: max_r <= merge(max_r, avs_writedata, avs_byteenable);
        `ECC_OFS_WDPRD: wdprd_r <= wdprd_mrg[15:0];
        `ECC_OFS_UPRD: uprd_r <= merge(uprd_r, avs_writedata, avs_byteenable);
        default: ctrl_r <= ctrl_r;
      endcase
    end
  end

  // Suspend gates, one per counter
  ecc_susp u_susp_pos (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .emu_suspend(emu_suspend),
    .emu_mode(emu_mode),
    .rollover(pos_roll),
    .run(run_p)
  ); // R01
  ecc_susp u_susp_wd (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .emu_suspend(emu_suspend),
    .emu_mode(emu_mode),
    .rollover(wd_match),
    .run(run_w)
  ); // R02
  ecc_susp u_susp_ut (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .emu_suspend(emu_suspend),
    .emu_mode(emu_mode),
    .rollover(unit_event),
    .run(run_u)
  ); // R03
  ecc_susp u_susp_ct (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .emu_suspend(emu_suspend),
    .emu_mode(emu_mode),
    .rollover(unit_event),
    .run(run_c)
  ); // R04

  // Unit timer
  assign u_match = ut_r == uprd_r;
  assign unit_event = run_u & u_match;

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ut_r <= `ECC_WORD_RST;
    end else if (run_u) begin
      ut_r <= u_match ? 32'h00000000 : ut_r + 32'h00000001; // R03
    end
  end

  // Capture timer: restarts on each count pulse, saturates
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ct_r <= `ECC_HALF_RST;
    end else if (run_c) begin
      if (count_pulse) begin
        ct_r <= 16'h0000;
      end else if (ct_r != 16'hffff) begin
        ct_r <= ct_r + 16'h0001; // R04
      end
    end
  end

  // Watchdog: prescaled, cleared by count pulses
  assign wd_tick = pre_r == `ECC_WD_PRESCALE;
  assign wd_match = run_w & wd_tick & !count_pulse & (wd_r == wdprd_r);

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_r <= 6'h00;
      wd_r <= `ECC_HALF_RST;
    end else if (run_w) begin
      pre_r <= pre_r + 6'h01;
      if (count_pulse || wd_match) begin
        wd_r <= 16'h0000; // R02
      end else if (wd_tick) begin
        wd_r <= wd_r + 16'h0001;
      end
    end
  end

  // Sticky status, set wins over write-one-to-clear
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wto_r <= 1'b0;
      uto_r <= 1'b0;
    end else begin
      wto_r <= wd_match | (wto_r & !(stat_wr & avs_byteenable[0] & avs_writedata[`ECC_STAT_WTO]));
      uto_r <= unit_event | (uto_r & !(stat_wr & avs_byteenable[0] & avs_writedata[`ECC_STAT_UTO]));
    end
  end

  // Index and strobe edges
  assign idx_rise = index_input & !idx_d_r;
  assign strb_rise = strobe_input & !strb_d_r;
  assign strb_fall = !strobe_input & strb_d_r;

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      idx_d_r <= 1'b0;
      strb_d_r <= 1'b0;
      arm_r <= 1'b0;
    end else begin
      idx_d_r <= index_input;
      strb_d_r <= strobe_input;
      // Arm on any control write; disarm after the first index
      if (ctrl_wr) begin
        arm_r <= 1'b1; // R07
      end else if (idx_rise) begin
        arm_r <= 1'b0; // R07
      end
    end
  end

  assign init_evt = (strobe_init_select == `ECC_SEI_RISE && strb_rise) || // R09 R10
    (strobe_init_select == `ECC_SEI_DIR && ((count_dir && strb_rise) || // R11
    (!count_dir && strb_fall))); // R12

  assign rst_evt = (position_reset_mode == `ECC_POSITION_RESET_MODE_INDEX && idx_rise) || // R05
    (position_reset_mode == `ECC_POSITION_RESET_MODE_FIRST && idx_rise && arm_r) || // R07
    (position_reset_mode == `ECC_POSITION_RESET_MODE_UNIT && unit_event); // R08

  // Position counter
  assign step = count_pulse & run_p;
  assign at_max = pos_r == max_r;
  assign at_zero = pos_r == 32'h00000000;
  assign pos_roll = count_pulse & ((count_dir & (position_reset_mode == `ECC_POSITION_RESET_MODE_MAX ? at_max : &pos_r)) |
    (!count_dir & at_zero));

  always @* begin
    pos_nxt = pos_r;
    if (init_evt) begin
      pos_nxt = init_r; // R13
    end else if (rst_evt) begin
      pos_nxt = 32'h00000000;
    end else if (step) begin
      if (position_reset_mode == `ECC_POSITION_RESET_MODE_MAX && count_dir && at_max) begin
        pos_nxt = 32'h00000000; // R06
      end else if (position_reset_mode == `ECC_POSITION_RESET_MODE_MAX && !count_dir && at_zero) begin
        pos_nxt = max_r; // R06
      end else if (count_dir) begin
        pos_nxt = pos_r + 32'h00000001;
      end else begin
        pos_nxt = pos_r - 32'h00000001;
      end
    end
  end

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pos_r <= `ECC_WORD_RST;
    end else begin
      pos_r <= pos_nxt; // R01
    end
  end

  assign position_count = pos_r;

endmodule // ecc_top

// ---- verification/ecc_chk_sva.sv ----
// Checker for ecc_top: position reset modes, strobe loads, suspend.
// Sees top ports only; shadows control, init and max writes.
`timescale 1ns/1ps
module ecc_chk (
  input wire ref_clk, // Clock
  input wire rst_b, // Reset
  input wire [5:0] avs_address, // Addr
  input wire avs_write, // Write
  input wire [31:0] avs_writedata, // Data
  input wire [3:0] avs_byteenable, // Lanes
  input wire avs_waitrequest, // Stall
  input wire count_pulse, // Count
  input wire count_dir, // Dir
  input wire index_input, // Index
  input wire strobe_input, // Strobe
  input wire emu_suspend, // Halt
  input wire [31:0] position_count, // Pos
  input wire unit_event // Unit
);
  default clocking dcb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic [15:0] ctl_r;
  logic [31:0] init_r;
  logic [31:0] max_r;
  logic arm_r;
  logic idx_q;
  wire wr = avs_write && !avs_waitrequest;
  wire [1:0] emu = ctl_r[15:14];
  wire [1:0] rm = ctl_r[13:12];
  wire [1:0] strobe_init_select = ctl_r[11:10];
  wire irise = index_input && !idx_q;
  function automatic logic [31:0] lanes(input logic [31:0] o, input logic [31:0] d, input logic [3:0] b);
    for (int i = 0; i < 4; i++) if (b[i]) o[i*8 +: 8] = d[i*8 +: 8];
    return o;
  endfunction
  wire [31:0] ctl_m = lanes({16'h0000, ctl_r}, avs_writedata, avs_byteenable);
  wire [31:0] init_m = lanes(init_r, avs_writedata, avs_byteenable);
  wire [31:0] max_m = lanes(max_r, avs_writedata, avs_byteenable);
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_r <= 16'h0000;
      init_r <= 32'h0;
      max_r <= 32'h0;
      arm_r <= 1'b0;
      idx_q <= 1'b0;
    end else begin
      idx_q <= index_input;
      if (wr && avs_address == 6'h00) ctl_r <= ctl_m[15:0];
      if (wr && avs_address == 6'h04) init_r <= init_m;
      if (wr && avs_address == 6'h08) max_r <= max_m;
      if (wr && avs_address == 6'h00) arm_r <= 1'b1;
      else if (irise) arm_r <= 1'b0;
    end
  end
  sequence s_noload;
    !irise && !unit_event && $stable(strobe_input);
  endsequence
  sequence s_rise_ld;
    $rose(strobe_input) && (strobe_init_select == 2'h2 || (strobe_init_select == 2'h3 && count_dir));
  endsequence
  chk_strobe_rise: assert property (s_rise_ld |=> position_count == init_r)
    else $error("strobe rise load wrong");
  chk_strobe_fall: assert property ($fell(strobe_input) && strobe_init_select == 2'h3 && !count_dir
    |=> position_count == init_r) else $error("strobe fall load wrong");
  chk_strobe_off: assert property ($rose(strobe_input) && !strobe_init_select[1] && !count_pulse && !irise
    && !unit_event |=> $stable(position_count)) else $error("strobe load while disabled");
  chk_index_reset: assert property (rm == 2'h0 && irise && $stable(strobe_input)
    |=> position_count == 32'h0) else $error("index reset missed");
  chk_unit_reset: assert property (rm == 2'h3 && unit_event && $stable(strobe_input)
    |=> position_count == 32'h0) else $error("unit reset missed");
  chk_first_index: assert property (rm == 2'h2 && irise && $stable(strobe_input) && !count_pulse
    |=> position_count == ($past(arm_r) ? 32'h0 : $past(position_count))) else $error("first index wrong");
  chk_max_reset: assert property (rm == 2'h1 && count_pulse && count_dir && !emu_suspend
    && position_count == max_r && $stable(strobe_input) |=> position_count == 32'h0)
    else $error("max reset missed");
  chk_susp_pos: assert property (emu_suspend && emu == 2'h0 ##0 s_noload
    |=> $stable(position_count)) else $error("position ran in halt");
  chk_susp_unit: assert property (emu_suspend && $past(emu_suspend) && emu == 2'h0
    |-> !unit_event) else $error("unit event in halt");
endmodule // ecc_chk
bind ecc_top ecc_chk ecc_chk_i (.ref_clk, .rst_b, .avs_address, .avs_write, .avs_writedata, .avs_byteenable,
  .avs_waitrequest, .count_pulse, .count_dir, .index_input, .strobe_input, .emu_suspend,
  .position_count, .unit_event);

// ---- verification/ecc_enc_model.sv ----
// Encoder stand-in: count pulses, direction, index and strobe lines.
// Bench sets the commands; outputs change just after ref_clk rises.
`timescale 1ns/1ps
module ecc_enc_model (
  input wire ref_clk, // Clock
  input wire rst_b, // Reset
  input wire run, // Rotate
  input wire dir, // Clockwise
  input wire idx_cmd, // Index level
  input wire stb_cmd, // Strobe level
  output logic count_pulse, // Count
  output logic count_dir, // Dir
  output logic index_input, // Index
  output logic strobe_input // Strobe
);
  logic [1:0] ph_r;
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ph_r <= 2'h0;
      count_pulse <= 1'b0;
      count_dir <= 1'b1;
      index_input <= 1'b0;
      strobe_input <= 1'b0;
    end else begin
      ph_r <= ph_r + 2'h1;
      count_pulse <= run && ph_r == 2'h3;
      count_dir <= dir;
      index_input <= idx_cmd;
      strobe_input <= stb_cmd;
    end
  end
endmodule // ecc_enc_model

// ---- verification/ecc_top_tb_top.sv ----
// Bench for ecc_top: register bus, reset modes, strobe loads, suspend.
// Encoder model drives the line inputs; the bench drives the bus.
`timescale 1ns/1ps
`include "ecc_defs.vh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR %s exp %h got %h", nm, e, g); end end
module ecc_top_tb_top;
  logic ref_clk = 1'b0, rst_b = 1'b0, avs_read = 1'b0, avs_write = 1'b0, emu_suspend = 1'b0;
  logic run = 1'b0, dir = 1'b1, idx = 1'b0, stb = 1'b0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [5:0] avs_address = 6'h00;
  logic [31:0] avs_writedata = 32'h0, rd, iv, p, x = 32'h1d;
  logic [31:0] v [4];
  logic [5:0] ad [4] = '{`ECC_OFS_UTCNT, `ECC_OFS_WDCNT, `ECC_OFS_CTCNT, `ECC_OFS_POS};
  wire [31:0] avs_readdata, position_count;
  wire avs_waitrequest, unit_event, count_pulse, count_dir, index_input, strobe_input;
  int mismatches = 0, n_compared = 0, cyc = 0, c = 0;
  always #12.5 ref_clk = ~ref_clk;
  ecc_enc_model ecc_enc_model_i (.ref_clk, .rst_b, .run, .dir, .idx_cmd(idx), .stb_cmd(stb),
    .count_pulse, .count_dir, .index_input, .strobe_input);
  ecc_top ecc_top_i (.ref_clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .count_pulse, .count_dir, .index_input,
    .strobe_input, .emu_suspend, .position_count, .unit_event);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic ld(input logic [1:0] s, input logic r, input logic d);
    return r ? (s == 2'h2 || (s == 2'h3 && d)) : (s == 2'h3 && !d);
  endfunction
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic pulse_index;
    idx <= 1'b1;
    wt(3);
    idx <= 1'b0;
    wt(3);
  endtask
  task complete_run;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 8000) begin
      mismatches++;
      complete_run();
    end
  end
  initial begin
    wt(5);
    rst_b <= 1'b1;
    bus(0, `ECC_OFS_CTRL, 32'h0);
    `CHK("ctrl reset", 32'h0, rd)
    bus(0, 6'h3c, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    $display("test registers done");
    for (int s = 0; s < 4; s++) begin
      for (int k = 0; k < 3; k++) begin
        x = xs(x);
        iv = x | 32'h1;
        bus(1, `ECC_OFS_CTRL, 32'h0);
        bus(1, `ECC_OFS_INIT, iv);
        stb <= (k == 2);
        dir <= (k == 0);
        wt(3);
        pulse_index();
        bus(1, `ECC_OFS_CTRL, s << 10);
        stb <= (k != 2);
        wt(4);
        `CHK("strobe", ld(s[1:0], k != 2, k == 0) ? iv : 32'h0, position_count)
      end
    end
    bus(1, `ECC_OFS_INIT, 32'hffffffff);
    avs_byteenable <= 4'h1;
    bus(1, `ECC_OFS_INIT, 32'h0);
    avs_byteenable <= 4'hf;
    bus(1, `ECC_OFS_CTRL, 32'h800);
    stb <= 1'b1;
    wt(4);
    `CHK("lane init", 32'hffffff00, position_count)
    $display("test strobe done");
    bus(1, `ECC_OFS_UPRD, 32'h9);
    bus(1, `ECC_OFS_CTRL, 32'h3000);
    run <= 1'b1;
    dir <= 1'b1;
    for (int i = 0; i < 30 && unit_event !== 1'b1; i++) @(negedge ref_clk);
    @(negedge ref_clk);
    `CHK("unit reset", 32'h0, position_count)
    bus(1, `ECC_OFS_MAX, 32'h5);
    bus(1, `ECC_OFS_CTRL, 32'h1000);
    repeat (60) begin
      @(negedge ref_clk);
      `CHK("max bound", 1'b1, position_count <= 32'h5)
    end
    for (int j = 0; j < 2; j++) begin
      if (j == 0) bus(1, `ECC_OFS_CTRL, 32'h2000);
      run <= 1'b1;
      wt(20);
      run <= 1'b0;
      wt(3);
      p = (j == 0) ? 32'h0 : position_count;
      pulse_index();
      `CHK("first index", p, position_count)
    end
    $display("test reset modes done");
    bus(1, `ECC_OFS_WDPRD, 32'hffff);
    for (int n = 0; n < 3; n++) begin
      // Code 01 first, while the unit timer is still inside its short period
      c = (n + 1) % 3;
      if (n == 1) bus(1, `ECC_OFS_UPRD, 32'h3e8);
      bus(1, `ECC_OFS_CTRL, c << 14);
      emu_suspend <= 1'b1;
      wt(12);
      for (int i = 0; i < 4; i++) begin
        bus(0, ad[i], 32'h0);
        v[i] = rd;
      end
      wt(140);
      for (int i = 0; i < 4; i++) begin
        bus(0, ad[i], 32'h0);
        `CHK("halt count", (c == 0 || i == 3 || (c == 1 && i != 1)), rd === v[i])
      end
      emu_suspend <= 1'b0;
      wt(2);
    end
    $display("test suspend done");
    complete_run();
  end
endmodule // ecc_top_tb_top
